/* File: verilog/bwcd_top.sv */
// Purpose: Decode, check and carry out the buffer write command
// Assumes: Descriptor, payload and store ports share clk with this block
// Notes:   Fields are checked before any flush or payload request
`default_nettype none

module bwcd_top
    import bwcd_pkg::*;
#(
    parameter logic [23:0]         BUF_BYTES   = 24'h100000,
    parameter logic [23:0]         SECTOR_MASK = 24'h0001ff,
    parameter logic [23:0]         IMAGE_BYTES = 24'h080000,
    parameter logic [7:0]          VU_ID_MAX   = 8'h03,
    parameter logic [BWCD_TMO_W-1:0] SAVE_CYC  = BWCD_TMO_W'(BWCD_SAVE_CYC)
) (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  cdb_valid,
    input  wire logic [BWCD_CDB_W-1:0] cdb_bytes,
    input  wire logic [7:0]            cdb_initiator,
    output var  logic                  cdb_ready,
    output var  logic                  flush_req,
    input  wire logic                  flush_done,
    output var  logic                  xfer_req,
    output var  logic [23:0]           xfer_len,
    input  wire logic                  din_valid,
    input  wire logic [7:0]            din_data,
    output var  logic                  din_ready,
    output var  logic                  store_valid,
    output var  logic [23:0]           store_addr,
    output var  logic [7:0]            store_data,
    input  wire logic                  store_ready,
    output var  logic [7:0]            store_target,
    output var  logic                  store_ucode,
    output var  logic                  ucode_run,
    output var  logic                  ucode_save_start,
    input  wire logic                  ucode_save_ok,
    input  wire logic                  ucode_save_bad,
    output var  logic                  self_reset_req,
    output var  logic                  ua_post,
    output var  logic [7:0]            ua_skip_initiator,
    output var  logic                  medium_write_inhibit,
    output var  logic                  sts_valid,
    output var  logic [7:0]            sts_code,
    output var  logic [3:0]            sense_key,
    output var  logic [7:0]            sense_asc
);

    bwcd_state_t     state_reg;
    bwcd_state_t     state_next;
    logic [4:0]      mode_reg;
    logic [7:0]      id_reg;
    logic [23:0]     off_reg;
    logic [23:0]     len_reg;
    logic [23:0]     rx_left_reg;
    logic [23:0]     hdr_left_reg;
    logic [23:0]     wr_cnt_reg;
    logic [BWCD_TMO_W-1:0] tmo_reg;
    logic            bad_reg;
    logic [3:0]      key_reg;
    logic [7:0]      asc_reg;
    logic            save_ok_reg;
    logic            save_bad_reg;

    // Descriptor fields
    wire [7:0]  f_op   = cdb_bytes[BWCD_OP_MSB -: 8];
    wire [4:0]  f_mode = cdb_bytes[BWCD_MODE_MSB -: 5];
    wire [7:0]  f_id   = cdb_bytes[BWCD_ID_MSB -: 8];
    wire [23:0] f_off  = cdb_bytes[BWCD_OFF_MSB -: BWCD_LEN_W];
    wire [23:0] f_len  = cdb_bytes[BWCD_LEN_MSB -: BWCD_LEN_W];
    wire        cdb_take = cdb_valid & cdb_ready;

    // Mode decode
    wire m_hdr  = (mode_reg == BWCD_M_HDR);
    wire m_data = (mode_reg == BWCD_M_DATA);
    wire m_vol  = (mode_reg == BWCD_M_UC_VOL);
    wire m_save = (mode_reg == BWCD_M_UC_SAVE);
    wire m_ok   = m_hdr | m_data | m_vol | m_save
                | (mode_reg == BWCD_M_UC_SEG) | (mode_reg == BWCD_M_ECHO)
                | (mode_reg == BWCD_M_UC_SEL) | (mode_reg == BWCD_M_UC_DEF)
                | (mode_reg == BWCD_M_UC_ACT) | (mode_reg == BWCD_M_EXPDR);

    // Field checks
    wire        id_zero   = (id_reg == BWCD_ID_MAIN);
    wire        off_zero  = (off_reg == BWCD_ZERO24);
    wire        len_zero  = (len_reg == BWCD_ZERO24);
    wire        hdr_short = (len_reg < BWCD_HDR_BYTES);
    wire [24:0] hdr_body  = {1'b0, len_reg} - {1'b0, BWCD_HDR_BYTES};
    wire        hdr_big   = !hdr_short && (hdr_body > {1'b0, BUF_BYTES});
    wire [24:0] end_pos   = {1'b0, off_reg} + {1'b0, len_reg};
    wire        off_big   = (off_reg >= BUF_BYTES);
    wire        data_len_bad = (end_pos >= {1'b0, BUF_BYTES})
                             || ((len_reg & SECTOR_MASK) != BWCD_ZERO24);
    wire        vol_id_bad = (id_reg > VU_ID_MAX);
    wire        img_bad    = !len_zero && (len_reg != IMAGE_BYTES);

    wire hdr_bad  = m_hdr && (!id_zero || !off_zero || hdr_big);
    wire data_bad = m_data && (!id_zero || off_big || (!len_zero && data_len_bad));
    wire vol_bad  = m_vol && (vol_id_bad || !off_zero || img_bad);
    wire save_bad = m_save && img_bad;
    wire chk_bad  = !m_ok || hdr_bad || data_bad || vol_bad || save_bad;

    // Payload needed only for storing modes with a real length
    wire need_xfer = (m_hdr && !hdr_short)
                   || ((m_data || m_vol || m_save) && !len_zero);

    // Link side of the payload path
    wire in_take  = din_valid & din_ready;
    wire in_hdr   = (hdr_left_reg != BWCD_ZERO24);
    wire buf_push = din_valid & ~in_hdr;
    wire st_take  = store_valid & store_ready;
    wire [23:0] rx_left_next = rx_left_reg - {23'h0, in_take};
    wire accept_en = (state_next == BWCD_XFER) && (rx_left_next != BWCD_ZERO24);
    wire rx_done  = (rx_left_reg == BWCD_ZERO24);
    wire tmo_hit  = (tmo_reg == SAVE_CYC);

    bwcd_skid2 #(
        .W         (8)
    ) u_buf (
        .clk       (clk),
        .reset     (reset),
        .accept_en (accept_en),
        .in_valid  (buf_push),
        .in_data   (din_data),
        .in_ready  (din_ready),
        .out_valid (store_valid),
        .out_data  (store_data),
        .out_ready (store_ready)
    );

    // Sequencer
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            BWCD_IDLE:
                if (cdb_take && f_op == BWCD_OPCODE)
                    state_next = BWCD_CHECK;
            BWCD_CHECK:
                state_next = chk_bad ? BWCD_STATUS : BWCD_FLUSH;
            BWCD_FLUSH:
                if (flush_done)
                    state_next = need_xfer ? BWCD_XFER : BWCD_STATUS;
            BWCD_XFER:
                if (rx_done)
                    state_next = BWCD_DRAIN;
            BWCD_DRAIN:
                if (!store_valid)
                    state_next = m_save ? BWCD_SAVE : BWCD_STATUS;
            BWCD_SAVE:
                if (save_ok_reg || save_bad_reg || tmo_hit)
                    state_next = BWCD_STATUS;
            BWCD_STATUS:
                state_next = BWCD_IDLE;
            default:
                state_next = BWCD_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            state_reg <= BWCD_IDLE;
        else
            state_reg <= state_next;
    end

    // Latch descriptor; mode-specific bits are dropped
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            mode_reg          <= BWCD_M_HDR;
            id_reg            <= BWCD_ID_MAIN;
            off_reg           <= BWCD_ZERO24;
            len_reg           <= BWCD_ZERO24;
            ua_skip_initiator <= 8'h00;
        end
        else if (cdb_take)
        begin
            mode_reg          <= f_mode;
            id_reg            <= f_id;
            off_reg           <= f_off;
            len_reg           <= f_len;
            ua_skip_initiator <= cdb_initiator;
        end
    end

    // Outcome of checks and save
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            bad_reg <= 1'b0;
            key_reg <= BWCD_SK_NONE;
            asc_reg <= BWCD_ASC_NONE;
        end
        else if (state_reg == BWCD_CHECK)
        begin
            bad_reg <= chk_bad;
            key_reg <= chk_bad ? BWCD_SK_ILLEG : BWCD_SK_NONE;
            asc_reg <= chk_bad ? BWCD_ASC_CDB : BWCD_ASC_NONE;
        end
        else if (state_reg == BWCD_SAVE && save_bad_reg)
        begin
            bad_reg <= 1'b1;
            key_reg <= BWCD_SK_ILLEG;
            asc_reg <= BWCD_ASC_PARM;
        end
        else if (state_reg == BWCD_SAVE && !save_ok_reg && tmo_hit)
        begin
            bad_reg <= 1'b1;
            key_reg <= BWCD_SK_HWERR;
            asc_reg <= BWCD_ASC_TMO;
        end
    end

    // Payload counters
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rx_left_reg  <= BWCD_ZERO24;
            hdr_left_reg <= BWCD_ZERO24;
            wr_cnt_reg   <= BWCD_ZERO24;
        end
        else if (state_reg == BWCD_FLUSH)
        begin
            rx_left_reg  <= len_reg;
            hdr_left_reg <= m_hdr ? BWCD_HDR_BYTES : BWCD_ZERO24;
            wr_cnt_reg   <= BWCD_ZERO24;
        end
        else
        begin
            rx_left_reg <= rx_left_next;
            if (in_take && in_hdr)
                hdr_left_reg <= hdr_left_reg - 24'h000001;
            if (st_take)
                wr_cnt_reg <= wr_cnt_reg + 24'h000001;
        end
    end

    // Store address and target
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            store_addr   <= BWCD_ZERO24;
            store_target <= BWCD_ID_MAIN;
            store_ucode  <= 1'b0;
        end
        else
        begin
            store_addr   <= off_reg + wr_cnt_reg + {23'h0, st_take};
            store_target <= id_reg;
            store_ucode  <= m_vol | m_save;
        end
    end

    // Save handshake and deadline
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            save_ok_reg  <= 1'b0;
            save_bad_reg <= 1'b0;
            tmo_reg      <= '0;
        end
        else if (state_reg != BWCD_SAVE)
        begin
            save_ok_reg  <= 1'b0;
            save_bad_reg <= 1'b0;
            tmo_reg      <= '0;
        end
        else
        begin
            save_ok_reg  <= save_ok_reg | ucode_save_ok;
            save_bad_reg <= save_bad_reg | ucode_save_bad;
            if (!tmo_hit)
                tmo_reg <= tmo_reg + {{(BWCD_TMO_W-1){1'b0}}, 1'b1};
        end
    end

    // Command side strobes
    wire enter_flush = (state_reg == BWCD_CHECK) && !chk_bad;
    wire enter_xfer  = (state_reg == BWCD_FLUSH) && flush_done && need_xfer;
    wire fin_good    = (state_reg == BWCD_STATUS) && !bad_reg;
    wire vol_done    = fin_good && m_vol && !len_zero;
    wire save_done   = (state_reg == BWCD_SAVE) && save_ok_reg && !save_bad_reg;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cdb_ready        <= 1'b0;
            flush_req        <= 1'b0;
            xfer_req         <= 1'b0;
            xfer_len         <= BWCD_ZERO24;
            ucode_run        <= 1'b0;
            ucode_save_start <= 1'b0;
            self_reset_req   <= 1'b0;
            ua_post          <= 1'b0;
        end
        else
        begin
            cdb_ready        <= (state_next == BWCD_IDLE) && !cdb_take;
            flush_req        <= enter_flush;
            xfer_req         <= enter_xfer;
            if (enter_xfer)
                xfer_len <= len_reg;
            ucode_run        <= vol_done;
            ucode_save_start <= (state_reg == BWCD_DRAIN) && !store_valid && m_save;
            self_reset_req   <= save_done;
            ua_post          <= vol_done;
        end
    end

    // Status report and medium guard
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sts_valid            <= 1'b0;
            sts_code             <= BWCD_ST_GOOD;
            sense_key            <= BWCD_SK_NONE;
            sense_asc            <= BWCD_ASC_NONE;
            medium_write_inhibit <= 1'b1;
        end
        else
        begin
            medium_write_inhibit <= 1'b1;
            sts_valid            <= (state_reg == BWCD_STATUS);
            if (state_reg == BWCD_STATUS)
            begin
                sts_code  <= bad_reg ? BWCD_ST_CHECK : BWCD_ST_GOOD;
                sense_key <= key_reg;
                sense_asc <= asc_reg;
            end
        end
    end

endmodule : bwcd_top

`default_nettype wire

/* File: verilog/bwcd_pkg.sv */
// Purpose: Shared constants for the buffer write command decoder
// Assumes: Ten-byte descriptor arrives as one 80-bit word, byte 0 in the top bits
// Notes:   Every offset, code and timing figure used by the decoder lives here
`default_nettype none

package bwcd_pkg;

    // Descriptor layout
    localparam int        BWCD_CDB_W     = 80;
    localparam int        BWCD_OP_MSB    = 79;
    localparam int        BWCD_MSPEC_MSB = 71;
    localparam int        BWCD_MODE_MSB  = 68;
    localparam int        BWCD_ID_MSB    = 63;
    localparam int        BWCD_OFF_MSB   = 55;
    localparam int        BWCD_LEN_MSB   = 31;
    localparam int        BWCD_LEN_W     = 24;
    localparam logic [7:0] BWCD_OPCODE   = 8'h3b;

    // Mode codes
    localparam logic [4:0] BWCD_M_HDR     = 5'h00;
    localparam logic [4:0] BWCD_M_DATA    = 5'h02;
    localparam logic [4:0] BWCD_M_UC_VOL  = 5'h04;
    localparam logic [4:0] BWCD_M_UC_SAVE = 5'h05;
    localparam logic [4:0] BWCD_M_UC_SEG  = 5'h07;
    localparam logic [4:0] BWCD_M_ECHO    = 5'h0a;
    localparam logic [4:0] BWCD_M_UC_SEL  = 5'h0d;
    localparam logic [4:0] BWCD_M_UC_DEF  = 5'h0e;
    localparam logic [4:0] BWCD_M_UC_ACT  = 5'h0f;
    localparam logic [4:0] BWCD_M_EXPDR   = 5'h1a;

    // Field values
    localparam logic [7:0]  BWCD_ID_MAIN   = 8'h00;
    localparam logic [23:0] BWCD_HDR_BYTES = 24'h000004;
    localparam logic [23:0] BWCD_ZERO24    = 24'h000000;

    // Status and sense
    localparam logic [7:0] BWCD_ST_GOOD   = 8'h00;
    localparam logic [7:0] BWCD_ST_CHECK  = 8'h02;
    localparam logic [3:0] BWCD_SK_NONE   = 4'h0;
    localparam logic [3:0] BWCD_SK_HWERR  = 4'h4;
    localparam logic [3:0] BWCD_SK_ILLEG  = 4'h5;
    localparam logic [7:0] BWCD_ASC_NONE  = 8'h00;
    localparam logic [7:0] BWCD_ASC_CDB   = 8'h24;
    localparam logic [7:0] BWCD_ASC_PARM  = 8'h26;
    localparam logic [7:0] BWCD_ASC_TMO   = 8'h44;

    // Timing: save completion deadline
    localparam longint BWCD_CLK_HZ      = 200_000_000;
    localparam longint BWCD_SAVE_TIME_S = 30;
    localparam longint BWCD_SAVE_CYC    = BWCD_SAVE_TIME_S * BWCD_CLK_HZ;
    localparam int     BWCD_TMO_W       = 36;

    // Sequencer states
    typedef enum logic [6:0] {
        BWCD_IDLE   = 7'b0000001,
        BWCD_CHECK  = 7'b0000010,
        BWCD_FLUSH  = 7'b0000100,
        BWCD_XFER   = 7'b0001000,
        BWCD_DRAIN  = 7'b0010000,
        BWCD_SAVE   = 7'b0100000,
        BWCD_STATUS = 7'b1000000
    } bwcd_state_t;

endpackage : bwcd_pkg

`default_nettype wire

/* File: verilog/bwcd_skid2.sv */
// Purpose: Two-entry buffer between the payload link and the store port
// Assumes: Push only while in_ready is high; in_ready is registered
// Notes:   accept_en says whether the next cycle may take a byte at all
`default_nettype none

module bwcd_skid2 #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         accept_en,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output var  logic         in_ready,
    output var  logic         out_valid,
    output var  logic [W-1:0] out_data,
    input  wire logic         out_ready
);

    logic [1:0]   level_reg;
    logic [1:0]   level_next;
    logic [W-1:0] tail_reg;
    wire          push = in_valid & in_ready;
    wire          pop  = out_valid & out_ready;

    // Occupancy after this cycle
    always_comb
    begin
        level_next = level_reg + {1'b0, push} - {1'b0, pop};
    end

    // Head, tail and level
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            level_reg <= 2'h0;
            tail_reg  <= '0;
            out_data  <= '0;
            out_valid <= 1'b0;
            in_ready  <= 1'b0;
        end
        else
        begin
            level_reg <= level_next;
            out_valid <= (level_next != 2'h0);
            in_ready  <= accept_en & (level_next != 2'h2);
            if (push && (level_reg == 2'h2 || (level_reg == 2'h1 && !pop)))
                tail_reg <= in_data;
            if (pop && level_reg == 2'h2)
                out_data <= tail_reg;
            else if (push && (level_reg == 2'h0 || (level_reg == 2'h1 && pop)))
                out_data <= in_data;
        end
    end

endmodule : bwcd_skid2

`default_nettype wire

/* File: tb/bwcd_assertions.sv */
// Purpose: Concurrent checks on the buffer write command decoder ports
// Assumes: One clock domain, reset asynchronous and active high
// Notes:   Bound into bwcd_top by the statement after the module
`default_nettype none

module bwcd_assertions
    import bwcd_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  reset,
    input wire logic                  cdb_valid,
    input wire logic [BWCD_CDB_W-1:0] cdb_bytes,
    input wire logic [7:0]            cdb_initiator,
    input wire logic                  cdb_ready,
    input wire logic                  flush_req,
    input wire logic                  flush_done,
    input wire logic                  xfer_req,
    input wire logic                  ucode_run,
    input wire logic                  ua_post,
    input wire logic [7:0]            ua_skip_initiator,
    input wire logic                  medium_write_inhibit,
    input wire logic                  sts_valid,
    input wire logic [7:0]            sts_code,
    input wire logic [3:0]            sense_key,
    input wire logic [7:0]            sense_asc
);
    localparam logic [31:0] MODE_OK = 32'h0400e4b5;
    // Descriptor fields seen at the take edge
    wire logic [7:0]  op   = cdb_bytes[BWCD_OP_MSB-:8];
    wire logic [4:0]  md   = cdb_bytes[BWCD_MODE_MSB-:5];
    wire logic [7:0]  id   = cdb_bytes[BWCD_ID_MSB-:8];
    wire logic [23:0] off  = cdb_bytes[BWCD_OFF_MSB-:24];
    wire logic        take = cdb_valid && cdb_ready && op == BWCD_OPCODE;
    logic             fl_reg;
    logic [7:0]       ini_reg;

    // Flush finished and issuer, kept for the running command
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            fl_reg  <= 1'b0;
            ini_reg <= 8'h00;
        end
        else
        begin
            fl_reg  <= (fl_reg || flush_done) && !sts_valid && !take;
            ini_reg <= take ? cdb_initiator : ini_reg;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Refusal: nothing requested, then illegal request status
    sequence rej_s;
        (!flush_req && !xfer_req) [*2] ##1 (sts_valid && sts_code == BWCD_ST_CHECK
        && sense_key == BWCD_SK_ILLEG && sense_asc == BWCD_ASC_CDB);
    endsequence

    chk_mwi_always: assert property (medium_write_inhibit)
        else $error("medium write not inhibited");
    chk_mode_reject: assert property (take && !MODE_OK[md] |=> rej_s)
        else $error("unsupported mode not refused");
    chk_hdr_fields: assert property (
        take && md == BWCD_M_HDR && (id != 8'h00 || off != 24'h000000) |=> rej_s)
        else $error("header mode field not refused");
    chk_data_id: assert property (take && md == BWCD_M_DATA && id != 8'h00 |=> rej_s)
        else $error("data mode buffer id not refused");
    chk_vol_offset: assert property (
        take && md == BWCD_M_UC_VOL && off != 24'h000000 |=> rej_s)
        else $error("volatile offset not refused");
    chk_flush_first: assert property (xfer_req |-> fl_reg)
        else $error("payload asked before flush done");
    chk_run_ua: assert property (
        ucode_run |-> ua_post && sts_valid && sts_code == BWCD_ST_GOOD)
        else $error("image run without attention and good status");
    chk_ua_skip: assert property (ua_post |-> ua_skip_initiator == ini_reg)
        else $error("attention skip id is not the issuer");
endmodule : bwcd_assertions

bind bwcd_top bwcd_assertions bwcd_assertions_i (.*);

`default_nettype wire

/* File: tb/bwcd_initiator.sv */
// Purpose: Initiator, cache and memory side model for the decoder
// Assumes: Payload bytes count up from 0 in every transfer
// Notes:   save_mode 0 good, 1 bad image, 2 never answers
`default_nettype none

module bwcd_initiator (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        stall,
    input  wire logic [1:0]  save_mode,
    input  wire logic        flush_req,
    output var  logic        flush_done,
    input  wire logic        xfer_req,
    input  wire logic [23:0] xfer_len,
    output var  logic        din_valid,
    output var  logic [7:0]  din_data,
    input  wire logic        din_ready,
    output var  logic        store_ready,
    input  wire logic        ucode_save_start,
    output var  logic        ucode_save_ok,
    output var  logic        ucode_save_bad
);
    logic [23:0]      left_reg;
    logic [7:0]       idx_reg;
    logic [3:0]       dly_reg;
    logic [3:0]       sv_reg;
    wire logic        fire   = din_valid && din_ready;
    wire logic [23:0] left_n = xfer_req ? xfer_len : left_reg - {23'h0, fire};

    // Released line shows the inverse of the next byte index (bytes sent so far)
    assign din_data = din_valid ? idx_reg : ~idx_reg;

    // Flush answer, payload stream held until taken, save result
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            {flush_done, din_valid, store_ready, ucode_save_ok, ucode_save_bad} <= 5'h00;
            {left_reg, idx_reg, dly_reg, sv_reg} <= '0;
        end
        else
        begin
            dly_reg        <= {dly_reg[2:0], flush_req};
            flush_done     <= dly_reg[2];
            left_reg       <= left_n;
            idx_reg        <= xfer_req ? 8'h00 : idx_reg + {7'h0, fire};
            din_valid      <= (din_valid && !din_ready) || (left_n != 0 && !(stall && store_ready));
            store_ready    <= stall ? !store_ready : 1'b1;
            sv_reg         <= ucode_save_start ? 4'h8 : sv_reg - {3'h0, sv_reg != 0};
            ucode_save_ok  <= sv_reg == 4'h1 && save_mode == 2'h0;
            ucode_save_bad <= sv_reg == 4'h1 && save_mode == 2'h1;
        end
    end
endmodule : bwcd_initiator

`default_nettype wire

/* File: tb/test_bwcd_top.sv */
// Purpose: Directed regression of the buffer write command decoder
// Assumes: Small buffer, sector and image sizes; save deadline of 100 cycles
// Notes:   Initiator and memory model stands at the far side
`default_nettype none

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected at %0t got %h expected %h", $time, g, e); end end

module test_bwcd_top
    import bwcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] MODE_OK = 32'h0400e4b5;
    logic        clk, reset, cdb_valid, cdb_ready, flush_req, flush_done, xfer_req;
    logic        din_valid, din_ready, store_valid, store_ready, store_ucode, ucode_run;
    logic        ucode_save_start, ucode_save_ok, ucode_save_bad, self_reset_req, ua_post;
    logic        medium_write_inhibit, sts_valid, stall;
    logic [79:0] cdb_bytes;
    logic [7:0]  cdb_initiator, din_data, store_data, store_target, ua_skip_initiator;
    logic [7:0]  sts_code, sense_asc, d0, sk0;
    logic [23:0] xfer_len, store_addr, a0, x0;
    logic [8:0]  t0;
    logic [3:0]  sense_key;
    logic [1:0]  save_mode;
    int          n_errors, num_checks, n_st, n_ua, n_run, n_sr, cyc;

    bwcd_top #(.BUF_BYTES(24'h000800), .SECTOR_MASK(24'h00000f), .IMAGE_BYTES(24'h000010),
        .VU_ID_MAX(8'h03), .SAVE_CYC(36'h064)) bwcd_top_i (.*);
    bwcd_initiator bwcd_initiator_i (.*);

    // Clock and cycle ceiling
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_errors++;
            end_sim();
        end
    end

    // Settled view of stores and pulses
    always @(negedge clk)
    begin
        if (store_valid && store_ready && n_st == 0)
            {a0, d0, t0} = {store_addr, store_data, store_ucode, store_target};
        if (xfer_req)
            x0 = xfer_len;
        n_st += int'(store_valid && store_ready);
        n_ua += int'(ua_post);
        n_run += int'(ucode_run);
        n_sr += int'(self_reset_req);
        if (ua_post)
            sk0 = ua_skip_initiator;
    end

    // One descriptor, status and store count compared
    task automatic cmd(input logic [4:0] m, input logic [7:0] id, input logic [23:0] off,
        input logic [23:0] len, input logic [3:0] k, input logic [7:0] a, input int ns);
        int w;
        @(negedge clk);
        {n_st, n_ua, n_run, n_sr} = '0;
        cdb_initiator = {3'h0, m};
        cdb_bytes = {BWCD_OPCODE, 3'h0, m, id, off, len, 8'h00};
        cdb_valid = 1'b1;
        while (!cdb_ready) @(negedge clk);
        @(negedge clk);
        cdb_valid = 1'b0;
        for (w = 0; !sts_valid && w < 400; w++) @(negedge clk);
        `CHK(sts_valid, 1'b1)
        `CHK(sts_code, (k == 4'h0) ? BWCD_ST_GOOD : BWCD_ST_CHECK)
        `CHK(sense_key, k)
        `CHK(sense_asc, a)
        `CHK(n_st, ns)
        repeat (3) @(negedge clk);
    endtask : cmd

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    // Directed command sequence
    initial
    begin
        {reset, cdb_valid, cdb_bytes, cdb_initiator, stall, save_mode} = {1'b1, 92'h0};
        repeat (3) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        for (int m = 0; m < 32; m++)
            cmd(m[4:0], 8'h00, 24'h0, 24'h0, MODE_OK[m] ? 4'h0 : BWCD_SK_ILLEG,
                MODE_OK[m] ? 8'h00 : BWCD_ASC_CDB, 0);
        cmd(BWCD_M_HDR, 8'h01, 24'h0, 24'h14, BWCD_SK_ILLEG, BWCD_ASC_CDB, 0);
        cmd(BWCD_M_HDR, 8'h00, 24'h4, 24'h14, BWCD_SK_ILLEG, BWCD_ASC_CDB, 0);
        cmd(BWCD_M_HDR, 8'h00, 24'h0, 24'h805, BWCD_SK_ILLEG, BWCD_ASC_CDB, 0);
        cmd(BWCD_M_HDR, 8'h00, 24'h0, 24'h3, 4'h0, 8'h00, 0);
        cmd(BWCD_M_HDR, 8'h00, 24'h0, 24'h14, 4'h0, 8'h00, 16);
        `CHK({a0, d0}, 32'h00000004)
        `CHK(x0, 24'h000014)
        cmd(BWCD_M_DATA, 8'h01, 24'h0, 24'h10, BWCD_SK_ILLEG, BWCD_ASC_CDB, 0);
        cmd(BWCD_M_DATA, 8'h00, 24'h800, 24'h10, BWCD_SK_ILLEG, BWCD_ASC_CDB, 0);
        cmd(BWCD_M_DATA, 8'h00, 24'h7f0, 24'h10, BWCD_SK_ILLEG, BWCD_ASC_CDB, 0);
        cmd(BWCD_M_DATA, 8'h00, 24'h0, 24'h18, BWCD_SK_ILLEG, BWCD_ASC_CDB, 0);
        stall = 1'b1;
        cmd(BWCD_M_DATA, 8'h00, 24'h20, 24'h20, 4'h0, 8'h00, 32);
        `CHK({a0, d0}, 32'h00002000)
        `CHK(t0, 9'h000)
        stall = 1'b0;
        cmd(BWCD_M_UC_VOL, 8'h04, 24'h0, 24'h10, BWCD_SK_ILLEG, BWCD_ASC_CDB, 0);
        cmd(BWCD_M_UC_VOL, 8'h00, 24'h1, 24'h10, BWCD_SK_ILLEG, BWCD_ASC_CDB, 0);
        cmd(BWCD_M_UC_VOL, 8'h00, 24'h0, 24'h8, BWCD_SK_ILLEG, BWCD_ASC_CDB, 0);
        cmd(BWCD_M_UC_VOL, 8'h03, 24'h0, 24'h10, 4'h0, 8'h00, 16);
        `CHK({n_run, n_ua, 24'h0, sk0}, {32'd1, 32'd1, 32'h4})
        `CHK(t0, 9'h103)
        cmd(BWCD_M_UC_SAVE, 8'h00, 24'h0, 24'h10, 4'h0, 8'h00, 16);
        `CHK(n_sr, 1)
        save_mode = 2'h1;
        cmd(BWCD_M_UC_SAVE, 8'h00, 24'h0, 24'h10, BWCD_SK_ILLEG, BWCD_ASC_PARM, 16);
        `CHK(n_sr, 0)
        save_mode = 2'h2;
        cmd(BWCD_M_UC_SAVE, 8'h00, 24'h0, 24'h10, BWCD_SK_HWERR, BWCD_ASC_TMO, 16);
        end_sim();
    end
endmodule : test_bwcd_top

`default_nettype wire
